// [hw/dsp_pkg.sv]
// Constants and types shared by the drive security password command block.
`default_nettype none

package dsp_pkg;

	// APB data and address width.
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [31:0] OFF_CMD = 32'h0000_0000;
	localparam logic [31:0] OFF_ERR = 32'h0000_0004;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0008;
	localparam logic [31:0] OFF_DATA = 32'h0000_000C;
	localparam logic [31:0] OFF_EVENT = 32'h0000_0010;
	localparam logic [31:0] OFF_SEC = 32'h0000_0014;
	localparam logic [31:0] OFF_IDENT92 = 32'h0000_0018;

	// Command codes.
	localparam logic [7:0] CMD_SET_PW = 8'hF1;
	localparam logic [7:0] CMD_UNLOCK = 8'hF2;

	// Error register field.
	localparam int ERR_ABORT_BIT = 2;

	// Status register fields.
	localparam int STS_BUSY_BIT = 7;
	localparam int STS_READY_BIT = 6;
	localparam int STS_SEEK_BIT = 4;
	localparam int STS_DRQ_BIT = 3;
	localparam int STS_ERR_BIT = 0;

	// Event register fields (write one to trigger).
	localparam int EVT_POWER_ON_BIT = 0;
	localparam int EVT_HARD_RESET_BIT = 1;

	// Security state register fields.
	localparam int SEC_LOCK_EN_BIT = 0;
	localparam int SEC_LOCKED_BIT = 1;
	localparam int SEC_LEVEL_MAX_BIT = 2;
	localparam int SEC_EXPIRED_BIT = 3;
	localparam int SEC_COUNT_LSB = 4;

	// Parameter block layout.
	localparam int CTRL_ROLE_BIT = 0;
	localparam int CTRL_LEVEL_BIT = 8;
	localparam int PW_WORDS = 16;
	localparam logic [7:0] PW_FIRST_WORD = 8'h01;
	localparam logic [7:0] PW_LAST_WORD = 8'h10;
	localparam logic [7:0] REV_WORD = 8'h11;
	localparam logic [7:0] LAST_WORD = 8'hFF;
	localparam logic [15:0] REV_NONE_LO = 16'h0000;
	localparam logic [15:0] REV_NONE_HI = 16'hFFFF;

	// Values after reset.
	localparam logic [2:0] ATTEMPT_INIT = 3'h5;
	localparam logic [15:0] REV_RESET = 16'h0000;

	// Command sequencer states, one-hot.
	typedef enum logic [2:0] {
		DSP_IDLE = 3'b001,
		DSP_XFER = 3'b010,
		DSP_EXEC = 3'b100
	} dsp_state_t;

endpackage : dsp_pkg

`default_nettype wire

// [hw/dsp_top.sv]
// Security set-password and unlock command interpreter behind an APB register port.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`default_nettype none

module dsp_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dsp_pkg::DATA_W-1:0] paddr,
	input wire logic [dsp_pkg::DATA_W-1:0] pwdata,
	output logic [dsp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Security state.
	output logic dev_locked
);
	import dsp_pkg::*;

	// Address match against one register word.
	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction : hit

	// Any mapped register.
	function automatic logic mapped(input logic [31:0] a);
		mapped = hit(a, OFF_CMD) || hit(a, OFF_ERR) || hit(a, OFF_STATUS) || hit(a, OFF_DATA) ||
			hit(a, OFF_EVENT) || hit(a, OFF_SEC) || hit(a, OFF_IDENT92);
	endfunction : mapped

	// Commands this block runs; an expired counter refuses both before any data moves.
	function automatic logic cmd_ok(input logic [7:0] code, input logic [2:0] left);
		cmd_ok = (code == CMD_SET_PW || code == CMD_UNLOCK) && left != 3'h0;
	endfunction : cmd_ok

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	dsp_state_t state_r;
	logic [7:0] cmd_r;
	logic [7:0] wcnt_r;
	logic role_master_r;
	logic level_max_in_r;
	logic mismatch_r;
	logic [15:0] rev_in_r;
	logic [15:0] user_pw_r [PW_WORDS];
	logic [15:0] master_pw_r [PW_WORDS];
	logic lock_en_r;
	logic locked_r;
	logic level_max_r;
	logic [2:0] attempts_r;
	logic [15:0] rev_r;
	logic abort_r;
	logic acc;
	logic wr;
	logic cmd_wr;
	logic data_wr;
	logic reset_evt;
	logic in_pw;
	logic [3:0] pw_idx;
	logic [15:0] ref_word;
	logic word_mismatch;
	logic exec_set;
	logic exec_unl;
	logic unl_reject;
	logic unl_fail;
	logic [7:0] status_byte;

	// A transfer completes at the edge where the access phase meets pready.
	assign acc = psel & penable & pready_r;
	assign wr = acc & pwrite;
	assign cmd_wr = wr & hit(paddr, OFF_CMD);
	assign data_wr = wr & hit(paddr, OFF_DATA) & (state_r == DSP_XFER);
	assign reset_evt = wr & hit(paddr, OFF_EVENT) & (pwdata[EVT_POWER_ON_BIT] | pwdata[EVT_HARD_RESET_BIT]);

	// Password word position within the sector and the stored word it is checked against.
	assign in_pw = (wcnt_r >= PW_FIRST_WORD) && (wcnt_r <= PW_LAST_WORD);
	assign pw_idx = 4'(wcnt_r - PW_FIRST_WORD);
	assign ref_word = role_master_r ? master_pw_r[pw_idx] : user_pw_r[pw_idx];
	assign word_mismatch = in_pw && (pwdata[15:0] != ref_word);

	// Completion step decisions.
	assign exec_set = (state_r == DSP_EXEC) && (cmd_r == CMD_SET_PW);
	assign exec_unl = (state_r == DSP_EXEC) && (cmd_r == CMD_UNLOCK);
	// Rejections that are not a compare failure, so the counter is left alone.
	assign unl_reject = (!role_master_r && !lock_en_r) || (role_master_r && level_max_r);
	assign unl_fail = exec_unl && !unl_reject && mismatch_r;

	// Status byte: ready and seek-complete always set, busy only while completing.
	always_comb begin
		status_byte = 8'h00;
		status_byte[STS_BUSY_BIT] = (state_r == DSP_EXEC);
		status_byte[STS_READY_BIT] = 1'b1;
		status_byte[STS_SEEK_BIT] = 1'b1;
		status_byte[STS_DRQ_BIT] = (state_r == DSP_XFER);
		status_byte[STS_ERR_BIT] = abort_r;
	end

	// APB answer: one wait cycle, then data and error are valid with pready.
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~mapped(paddr);
			if (psel & penable & ~pready_r & ~pwrite) begin
				if (hit(paddr, OFF_ERR)) begin
					prdata_r <= {29'h0, abort_r, 2'h0};
				end else if (hit(paddr, OFF_STATUS)) begin
					prdata_r <= {24'h00_0000, status_byte};
				end else if (hit(paddr, OFF_SEC)) begin
					prdata_r <= {25'h0, attempts_r, (attempts_r == 3'h0), level_max_r, locked_r, lock_en_r};
				end else if (hit(paddr, OFF_IDENT92)) begin
					prdata_r <= {16'h0000, rev_r};
				end else begin
					prdata_r <= 32'h0000_0000;
				end
			end
		end
	end

	// Command sequencer. Commands written while one is running are ignored, as the
	// host is expected to wait for busy and data request to clear first.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= DSP_IDLE;
			cmd_r <= 8'h00;
			wcnt_r <= 8'h00;
		end else begin
			case (state_r)
				DSP_IDLE: begin
					if (cmd_wr) begin
						cmd_r <= pwdata[7:0];
						wcnt_r <= 8'h00;
						// Expired counter and unknown codes abort before any data moves.
						if (cmd_ok(pwdata[7:0], attempts_r)) begin
							state_r <= DSP_XFER;
						end
					end
				end
				DSP_XFER: begin
					if (data_wr) begin
						wcnt_r <= wcnt_r + 8'h01;
						if (wcnt_r == LAST_WORD) begin
							state_r <= DSP_EXEC;
						end
					end
				end
				DSP_EXEC: begin
					state_r <= DSP_IDLE;
				end
				default: begin
					state_r <= DSP_IDLE;
				end
			endcase
		end
	end

	// Parameter block capture: control word, running compare and revision word.
	always_ff @(posedge clk) begin
		if (srst) begin
			role_master_r <= 1'b0;
			level_max_in_r <= 1'b0;
			mismatch_r <= 1'b0;
			rev_in_r <= REV_RESET;
		end else if (data_wr) begin
			if (wcnt_r == 8'h00) begin
				// Reserved control bits are dropped here.
				role_master_r <= pwdata[CTRL_ROLE_BIT];
				level_max_in_r <= pwdata[CTRL_LEVEL_BIT];
				mismatch_r <= 1'b0;
			end else begin
				mismatch_r <= mismatch_r | word_mismatch;
			end
			if (wcnt_r == REV_WORD) begin
				rev_in_r <= pwdata[15:0];
			end
		end
	end

	// Password stores. A set writes words straight into the chosen store as they arrive;
	// set-password cannot fail after its data, so no staging copy is needed.
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < PW_WORDS; i++) begin
				user_pw_r[i] <= 16'h0000;
				master_pw_r[i] <= 16'h0000;
			end
		end else if (data_wr && in_pw && cmd_r == CMD_SET_PW) begin
			if (role_master_r) begin
				master_pw_r[pw_idx] <= pwdata[15:0];
			end else begin
				user_pw_r[pw_idx] <= pwdata[15:0];
			end
		end
	end

	// Security state: lock enable, lock, level and revision code.
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_en_r <= 1'b0;
			locked_r <= 1'b0;
			level_max_r <= 1'b0;
			rev_r <= REV_RESET;
		end else if (reset_evt) begin
			// Locking follows the user password only; a master password alone never locks.
			locked_r <= lock_en_r;
		end else if (exec_set) begin
			if (role_master_r) begin
				if (rev_in_r != REV_NONE_LO && rev_in_r != REV_NONE_HI) begin
					rev_r <= rev_in_r;
				end
			end else begin
				lock_en_r <= 1'b1;
				level_max_r <= level_max_in_r;
			end
		end else if (exec_unl && !unl_reject && !mismatch_r) begin
			locked_r <= 1'b0;
		end
	end

	// Unlock attempt counter, reloaded by power-on and hard reset events.
	always_ff @(posedge clk) begin
		if (srst) begin
			attempts_r <= ATTEMPT_INIT;
		end else if (reset_evt) begin
			attempts_r <= ATTEMPT_INIT;
		end else if (unl_fail && attempts_r != 3'h0) begin
			attempts_r <= attempts_r - 3'h1;
		end
	end

	// Abort flag: cleared by an accepted command, set at refusal or at the completion of a failed unlock.
	always_ff @(posedge clk) begin
		if (srst) begin
			abort_r <= 1'b0;
		end else if (state_r == DSP_IDLE && cmd_wr) begin
			abort_r <= !cmd_ok(pwdata[7:0], attempts_r);
		end else if (exec_unl) begin
			abort_r <= unl_reject || mismatch_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign dev_locked = locked_r;

	// Checks on the command behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_cmd_ok;
		state_r == DSP_IDLE && cmd_wr && cmd_ok(pwdata[7:0], attempts_r);
	endsequence

	sequence s_last_word;
		data_wr && wcnt_r == LAST_WORD;
	endsequence

	cmd_to_xfer_a: assert property (s_cmd_ok |=> state_r == DSP_XFER && status_byte[STS_DRQ_BIT])
		else $error("accepted command did not request data");

	sector_end_a: assert property (s_last_word |=> state_r == DSP_EXEC
		##1 state_r == DSP_IDLE && !status_byte[STS_BUSY_BIT])
		else $error("sector end did not complete command");

	expired_a: assert property (state_r == DSP_IDLE && cmd_wr && attempts_r == 3'h0
		|=> state_r == DSP_IDLE && abort_r)
		else $error("command accepted with expired counter");

	decrement_a: assert property (unl_fail && attempts_r != 3'h0
		|=> attempts_r == $past(attempts_r) - 3'h1 && abort_r)
		else $error("mismatch did not decrement counter");

	reload_a: assert property (reset_evt |=> attempts_r == ATTEMPT_INIT && locked_r == $past(lock_en_r))
		else $error("reset event did not reload state");

	user_set_a: assert property (exec_set && !role_master_r |=> lock_en_r && !locked_r == !$past(locked_r))
		else $error("user set did not enable lock");

	master_set_a: assert property (exec_set && role_master_r |=> lock_en_r == $past(lock_en_r))
		else $error("master set changed lock enable");

	revision_a: assert property (exec_set && role_master_r &&
		(rev_in_r == REV_NONE_LO || rev_in_r == REV_NONE_HI) |=> rev_r == $past(rev_r))
		else $error("reserved revision code stored");

	unlock_ok_a: assert property (exec_unl && !unl_reject && !mismatch_r |=> !locked_r && !abort_r)
		else $error("good unlock did not clear lock");

	reject_a: assert property (exec_unl && unl_reject |=> abort_r && attempts_r == $past(attempts_r))
		else $error("rejected unlock mishandled");

	// Register answers, checked one cycle after the first access-phase cycle of a read.
	sequence s_rd_wait;
		psel && penable && !pready_r && !pwrite;
	endsequence

	unmapped_read_a: assert property (s_rd_wait && !mapped(paddr)
		|=> pready_r && pslverr_r && prdata_r == 32'h0000_0000)
		else $error("unmapped read was not refused");

	ident_word_a: assert property (s_rd_wait && hit(paddr, OFF_IDENT92)
		|=> prdata_r[15:0] == $past(rev_r))
		else $error("revision code missing from identify word");

	abort_bit_a: assert property (s_rd_wait && hit(paddr, OFF_ERR)
		|=> prdata_r[ERR_ABORT_BIT] == $past(abort_r))
		else $error("abort bit not reported in the error register");

	// Command and parameter checks. A refused command must leave the sequencer idle so
	// that no data phase follows an abort reported before the transfer.
	cmd_refused_a: assert property (state_r == DSP_IDLE && cmd_wr && !cmd_ok(pwdata[7:0], attempts_r)
		|=> state_r == DSP_IDLE && abort_r && !status_byte[STS_DRQ_BIT])
		else $error("refused command opened a data phase");

	control_word_a: assert property (data_wr && wcnt_r == 8'h00
		|=> role_master_r == $past(pwdata[CTRL_ROLE_BIT]) && level_max_in_r == $past(pwdata[CTRL_LEVEL_BIT]))
		else $error("control word fields not captured");

	revision_ok_a: assert property (exec_set && role_master_r &&
		rev_in_r != REV_NONE_LO && rev_in_r != REV_NONE_HI |=> rev_r == $past(rev_in_r))
		else $error("valid revision code not stored");

	master_high_a: assert property (exec_unl && role_master_r && !level_max_r && !mismatch_r
		|=> !locked_r && !abort_r)
		else $error("master password refused at high level");

	master_max_a: assert property (exec_unl && role_master_r && level_max_r
		|=> abort_r && locked_r == $past(locked_r))
		else $error("master unlock accepted at maximum level");

	user_off_a: assert property (exec_unl && !role_master_r && !lock_en_r |=> abort_r)
		else $error("user unlock with locking off not aborted");

	mismatch_keep_a: assert property (unl_fail |=> abort_r && locked_r == $past(locked_r))
		else $error("mismatched unlock released the lock");

	expired_hold_a: assert property (attempts_r == 3'h0 && !reset_evt |=> attempts_r == 3'h0)
		else $error("expired counter moved without a reset event");

endmodule : dsp_top

`default_nettype wire

// [tb/dsp_host.sv]
// Host adapter model that issues APB transfers, task-file commands and parameter sectors.
`default_nettype none

module dsp_host (
	// Clock.
	input wire logic clk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [dsp_pkg::DATA_W-1:0] paddr,
	output logic [dsp_pkg::DATA_W-1:0] pwdata,
	input wire logic [dsp_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	import dsp_pkg::*;

	// The bus idles deselected until the bench asks for a transfer.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
	end

	// One transfer: setup, then an access phase held until pready is seen high at a rising edge.
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		// Address and write data are inverted on release so that a stale value is never taken for a fresh one.
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

	// Writes the code that starts a set-password or an unlock operation.
	task automatic send_cmd(input logic [7:0] code);
		logic [31:0] rd;
		logic er;
		xfer(1'b1, OFF_CMD, {24'h00_0000, code}, rd, er);
	endtask : send_cmd

	// Hands over exactly one sector of 256 parameter words, word 0 first.
	task automatic send_sector(input logic [15:0] blk [256]);
		logic [31:0] rd;
		logic er;
		for (int i = 0; i < 256; i++) xfer(1'b1, OFF_DATA, {16'h0000, blk[i]}, rd, er);
	endtask : send_sector

endmodule : dsp_host

`default_nettype wire

// [tb/test_drive_security_password_unlock.sv]
// Self-checking bench for the password set and unlock command block.
`default_nettype none

module test_drive_security_password_unlock;
	timeunit 1ns;
	timeprecision 1ps;
	import dsp_pkg::*;

	// One command step; abt is 0 for success, 1 for abort after data, 2 for abort before data.
	typedef struct packed {logic [7:0] cmd; logic [15:0] ctrl; logic [15:0] pw; logic [15:0] rev;
		logic [1:0] evt; logic [1:0] abt; logic [7:0] sec; logic lk;} dsp_row_t;

	localparam int LIMIT = 60000;
	localparam logic [15:0] PM = 16'hA100;
	localparam logic [15:0] PU = 16'hB200;
	localparam logic [15:0] PV = 16'hC300;

	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dev_locked;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] rst_addr [4] = '{OFF_ERR, OFF_STATUS, OFF_SEC, OFF_IDENT92};
	logic [15:0] rst_val [4] = '{16'h0000, 16'h0050, 16'h0050, 16'h0000};

	// Control bit 15 is reserved, so the bench uses it to corrupt only the last password word.
	dsp_row_t rows [19] = '{
		'{CMD_SET_PW, 16'h0001, PM, 16'h1234, 2'h1, 2'h0, 8'h50, 1'b0},
		'{CMD_SET_PW, 16'h0001, PM, 16'hFFFF, 2'h0, 2'h0, 8'h50, 1'b0},
		'{CMD_SET_PW, 16'h0101, PM, 16'h0000, 2'h1, 2'h0, 8'h50, 1'b0},
		'{CMD_SET_PW, 16'h0000, PU, 16'h0000, 2'h1, 2'h0, 8'h53, 1'b1},
		'{CMD_UNLOCK, 16'h0001, PM, 16'h0000, 2'h0, 2'h0, 8'h51, 1'b0},
		'{CMD_UNLOCK, 16'h0000, PU, 16'h0000, 2'h2, 2'h0, 8'h53, 1'b1},
		'{CMD_UNLOCK, 16'h8000, PU, 16'h0000, 2'h0, 2'h1, 8'h43, 1'b1},
		'{CMD_UNLOCK, 16'h0000, PU, 16'h0000, 2'h0, 2'h0, 8'h41, 1'b0},
		'{CMD_SET_PW, 16'h0100, PV, 16'h0000, 2'h1, 2'h0, 8'h57, 1'b1},
		'{CMD_UNLOCK, 16'h0001, PM, 16'h0000, 2'h0, 2'h1, 8'h57, 1'b1},
		'{CMD_UNLOCK, 16'h0000, PV, 16'h0000, 2'h0, 2'h0, 8'h55, 1'b0},
		'{8'h00, 16'h0000, PV, 16'h0000, 2'h0, 2'h2, 8'h55, 1'b0},
		'{CMD_UNLOCK, 16'h8000, PV, 16'h0000, 2'h0, 2'h1, 8'h45, 1'b0},
		'{CMD_UNLOCK, 16'h8000, PV, 16'h0000, 2'h0, 2'h1, 8'h35, 1'b0},
		'{CMD_UNLOCK, 16'h8000, PV, 16'h0000, 2'h0, 2'h1, 8'h25, 1'b0},
		'{CMD_UNLOCK, 16'h8000, PV, 16'h0000, 2'h0, 2'h1, 8'h15, 1'b0},
		'{CMD_UNLOCK, 16'h8000, PV, 16'h0000, 2'h0, 2'h1, 8'h0D, 1'b0},
		'{CMD_UNLOCK, 16'h0000, PV, 16'h0000, 2'h0, 2'h2, 8'h0D, 1'b0},
		'{CMD_SET_PW, 16'h0000, PV, 16'h0000, 2'h2, 2'h2, 8'h57, 1'b1}
	};

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	dsp_host i_dsp_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	dsp_top i_dsp_top (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_locked(dev_locked));

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// Counts one comparison and reports it at once if it failed.
	task automatic chk(input logic ok, input string what);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t ns: %s", $time, what);
		end
	endtask : chk

	task automatic rd_reg(input logic [31:0] a, output logic [31:0] rd);
		logic er;
		i_dsp_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
	endtask : rd_reg

	// Issues one command, sends its sector unless it aborts before data, waits for completion and checks the outcome.
	task automatic run(input dsp_row_t r);
		logic [15:0] blk [256];
		logic [31:0] rd;
		int n;
		for (int i = 0; i < 256; i++) blk[i] = 16'h0000;
		blk[0] = r.ctrl;
		for (int i = 1; i <= 16; i++) blk[i] = r.pw + 16'(i);
		blk[16] = blk[16] ^ {r.ctrl[15], 15'h0000};
		blk[17] = r.rev;
		i_dsp_host.send_cmd(r.cmd);
		rd_reg(OFF_STATUS, rd);
		chk(rd[STS_DRQ_BIT] === (r.abt != 2'h2), "data request after command");
		if (r.abt != 2'h2)
			i_dsp_host.send_sector(blk);
		else
			chk(rd[STS_ERR_BIT] === 1'b1, "abort before data");
		n = 0;
		do begin
			rd_reg(OFF_STATUS, rd);
			n++;
		end while ((rd[STS_BUSY_BIT] | rd[STS_DRQ_BIT]) !== 1'b0 && n < 50);
		chk(rd[7:0] === (8'h50 | 8'(r.abt != 2'h0)), "status after completion");
		rd_reg(OFF_ERR, rd);
		chk(rd[ERR_ABORT_BIT] === (r.abt != 2'h0), "abort flag");
		if (r.evt != 2'h0)
			i_dsp_host.xfer(1'b1, OFF_EVENT, {30'h0, r.evt}, rd, n[0]);
		rd_reg(OFF_SEC, rd);
		chk(rd[7:0] === r.sec, "security state");
		chk(dev_locked === r.lk, "locked output");
	endtask : run

	// Cycle ceiling so that a hung handshake still reaches the report.
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// Ordinary rows first, then a mid-run reset, an unmapped access and an unlock with locking off.
	initial begin
		logic [31:0] rd;
		logic er;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			run(rows[i]);
			rd_reg(OFF_IDENT92, rd);
			chk(rd[15:0] === 16'h1234, "revision code");
			$display("row %0d done", i);
		end
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		foreach (rst_addr[i]) begin
			rd_reg(rst_addr[i], rd);
			chk(rd[15:0] === rst_val[i], "value after reset");
		end
		chk(dev_locked === 1'b0, "unlocked after reset");
		i_dsp_host.xfer(1'b0, 32'h0000_0040, 32'h0000_0000, rd, er);
		chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped address");
		$display("reset and unmapped tests done");
		run('{CMD_UNLOCK, 16'h0000, PU, 16'h0000, 2'h0, 2'h1, 8'h50, 1'b0});
		$display("unlock with locking off done");
		tally_and_finish();
	end

endmodule : test_drive_security_password_unlock

`default_nettype wire
